// ---- common/pei_pkg.sv ----
// Purpose: Shared constants for the power enable and reset/identity register bank
// Assumes: 16-bit registers behind an 8-bit register address
// Notes: Family code value is arbitrary
package pei_pkg;
  localparam int DATA_W = 16;
  localparam int ADDR_W = 8;

  // Register addresses
  localparam logic [7:0] ADDR_RESET_ID = 8'h00;
  localparam logic [7:0] ADDR_PWR_ONE = 8'h01;
  localparam logic [7:0] ADDR_PWR_TWO = 8'h02;

  // Family code, arbitrary value
  localparam logic [15:0] FAMILY_CODE = 16'h5a3c;

  // Power control one fields
  localparam int P1_MIC_BIAS_BIT = 4;
  localparam int P1_MIDRAIL_LSB = 1;
  localparam int P1_MIDRAIL_MSB = 2;
  localparam int P1_REF_BIAS_BIT = 0;

  // Power control two fields
  localparam int P2_FREQ_SYNTH_BIT = 15;
  localparam int P2_THERMAL_BIT = 14;
  localparam int P2_CLK_OUT_BIT = 11;
  localparam int P2_LEFT_PATH_BIT = 9;
  localparam int P2_RIGHT_PATH_BIT = 8;
  localparam int P2_LEFT_GAIN_B_BIT = 7;
  localparam int P2_LEFT_GAIN_A_BIT = 6;
  localparam int P2_RIGHT_GAIN_B_BIT = 5;
  localparam int P2_RIGHT_GAIN_A_BIT = 4;
  localparam int P2_LEFT_CONV_BIT = 1;
  localparam int P2_RIGHT_CONV_BIT = 0;

  // Writable bit masks and reset values
  localparam logic [15:0] PWR_ONE_MASK = 16'h0017;
  localparam logic [15:0] PWR_TWO_MASK = 16'hcbf3;
  localparam logic [15:0] PWR_ONE_RESET = 16'h0000;
  localparam logic [15:0] PWR_TWO_RESET = 16'h0000;
  localparam logic [15:0] READ_ZERO = 16'h0000;

  // Mid-rail divider selection
  typedef enum logic [1:0] {
    PEI_MIDRAIL_OFF = 2'h0,
    PEI_MIDRAIL_NORMAL = 2'h1,
    PEI_MIDRAIL_STANDBY = 2'h2,
    PEI_MIDRAIL_FAST = 2'h3
  } pei_midrail_t;
endpackage : pei_pkg

// ---- common/pei_reg_if.sv ----
// Purpose: Carries write, clear and value of one held register
// Assumes: Single clock domain
// Notes: Owner holds the value, user drives the strobes
`timescale 1ns/100ps
interface pei_reg_if;
  logic wr;
  logic clear;
  logic [15:0] wdata;
  logic [15:0] value;
  modport owner (input wr, input clear, input wdata, output value);
  modport user (output wr, output clear, output wdata, input value);
endinterface : pei_reg_if

// ---- design/pei_field_reg.sv ----
// Purpose: One masked read/write register with default restore
// Assumes: Strobes are one-cycle pulses
// Notes: Bits outside the mask stay zero
`timescale 1ns/100ps
module pei_field_reg #(
  parameter logic [15:0] MASK = 16'hffff,
  parameter logic [15:0] RESET_VALUE = 16'h0000
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Register carrier
  pei_reg_if.owner port
);
  logic [15:0] value_reg;

  // Default restore wins over a write
  always_ff @(posedge clk) begin
    if (rst || port.clear) begin
      value_reg <= RESET_VALUE & MASK;
    end else if (port.wr) begin
      value_reg <= port.wdata & MASK;
    end
  end

  assign port.value = value_reg;
endmodule : pei_field_reg

// ---- design/pei_power_regs.sv ----
// Purpose: Power enable registers plus reset/identity register
// Assumes: Register port driven by the serial control logic, inputs synchronous
// Notes: Enables reach the analogue blocks as plain levels
`timescale 1ns/100ps
module pei_power_regs (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Register port
  input wire logic [pei_pkg::ADDR_W-1:0] reg_addr,
  input wire logic reg_wr,
  input wire logic [pei_pkg::DATA_W-1:0] reg_wdata,
  input wire logic reg_rd,
  output logic [pei_pkg::DATA_W-1:0] reg_rdata,
  output logic reg_rvalid,
  // Soft reset to the rest of the device
  output logic soft_reset_pulse,
  // Power control one
  output logic mic_bias_on,
  output logic mic_bias_drive_en,
  output logic [1:0] midrail_mode,
  output logic reference_bias_on,
  // Power control two
  output logic freq_synth_on,
  output logic thermal_sensor_on,
  output logic clock_out_pin_on,
  output logic left_input_path_on,
  output logic right_input_path_on,
  output logic left_gain_stage_b_on,
  output logic left_gain_stage_a_on,
  output logic right_gain_stage_b_on,
  output logic right_gain_stage_a_on,
  output logic left_converter_on,
  output logic right_converter_on
);
  import pei_pkg::*;

  pei_reg_if pwr_one_if ();
  pei_reg_if pwr_two_if ();

  logic soft_clear;
  logic [15:0] rdata_next;

  // Write decode
  always_comb begin
    soft_clear = reg_wr && (reg_addr == ADDR_RESET_ID);
    pwr_one_if.wr = reg_wr && (reg_addr == ADDR_PWR_ONE);
    pwr_two_if.wr = reg_wr && (reg_addr == ADDR_PWR_TWO);
    pwr_one_if.clear = soft_clear;
    pwr_two_if.clear = soft_clear;
    pwr_one_if.wdata = reg_wdata;
    pwr_two_if.wdata = reg_wdata;
  end

  // Power registers, masked, zero default
  pei_field_reg #(
    .MASK(PWR_ONE_MASK),
    .RESET_VALUE(PWR_ONE_RESET)
  ) u_pwr_one (
    .clk(clk),
    .rst(rst),
    .port(pwr_one_if)
  );

  pei_field_reg #(
    .MASK(PWR_TWO_MASK),
    .RESET_VALUE(PWR_TWO_RESET)
  ) u_pwr_two (
    .clk(clk),
    .rst(rst),
    .port(pwr_two_if)
  );

  // Read mux
  always_comb begin
    case (reg_addr)
      ADDR_RESET_ID: rdata_next = FAMILY_CODE;
      ADDR_PWR_ONE: rdata_next = pwr_one_if.value & PWR_ONE_MASK;
      ADDR_PWR_TWO: rdata_next = pwr_two_if.value & PWR_TWO_MASK;
      default: rdata_next = READ_ZERO;
    endcase
  end

  // Read answer one cycle after the strobe
  always_ff @(posedge clk) begin
    if (rst) begin
      reg_rdata <= READ_ZERO;
      reg_rvalid <= 1'b0;
    end else begin
      reg_rvalid <= reg_rd;
      if (reg_rd) begin
        reg_rdata <= rdata_next;
      end
    end
  end

  // Soft reset notice to the rest of the device
  always_ff @(posedge clk) begin
    if (rst) begin
      soft_reset_pulse <= 1'b0;
    end else begin
      soft_reset_pulse <= soft_clear;
    end
  end

  // Enable levels, straight from register flops
  assign mic_bias_on = pwr_one_if.value[P1_MIC_BIAS_BIT];
  assign mic_bias_drive_en = pwr_one_if.value[P1_MIC_BIAS_BIT];
  assign midrail_mode = pwr_one_if.value[P1_MIDRAIL_MSB:P1_MIDRAIL_LSB];
  assign reference_bias_on = pwr_one_if.value[P1_REF_BIAS_BIT];
  assign freq_synth_on = pwr_two_if.value[P2_FREQ_SYNTH_BIT];
  assign thermal_sensor_on = pwr_two_if.value[P2_THERMAL_BIT];
  assign clock_out_pin_on = pwr_two_if.value[P2_CLK_OUT_BIT];
  assign left_input_path_on = pwr_two_if.value[P2_LEFT_PATH_BIT];
  assign right_input_path_on = pwr_two_if.value[P2_RIGHT_PATH_BIT];
  assign left_gain_stage_b_on = pwr_two_if.value[P2_LEFT_GAIN_B_BIT];
  assign left_gain_stage_a_on = pwr_two_if.value[P2_LEFT_GAIN_A_BIT];
  assign right_gain_stage_b_on = pwr_two_if.value[P2_RIGHT_GAIN_B_BIT];
  assign right_gain_stage_a_on = pwr_two_if.value[P2_RIGHT_GAIN_A_BIT];
  assign left_converter_on = pwr_two_if.value[P2_LEFT_CONV_BIT];
  assign right_converter_on = pwr_two_if.value[P2_RIGHT_CONV_BIT];
endmodule : pei_power_regs

// ---- verification/pei_power_monitor.sv ----
// Purpose: Port checker for pei_power_regs
// Assumes: One clock, rst synchronous
// Notes: Bound from tb
`timescale 1ns/100ps
module pei_power_monitor (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Register port
  input wire logic [7:0] reg_addr,
  input wire logic reg_wr,
  input wire logic [15:0] reg_wdata,
  input wire logic reg_rd,
  input wire logic [15:0] reg_rdata,
  input wire logic reg_rvalid,
  // Enables
  input wire logic soft_reset_pulse,
  input wire logic mic_bias_on,
  input wire logic mic_bias_drive_en,
  input wire logic [1:0] midrail_mode,
  input wire logic reference_bias_on,
  input wire logic freq_synth_on,
  input wire logic left_converter_on
);
  import pei_pkg::*;
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  a_rd_valid: assert property (reg_rd |=> reg_rvalid) else $error("no rvalid");
  a_rv_idle: assert property (!reg_rd |=> !reg_rvalid) else $error("stray rvalid");
  a_id_read: assert property (reg_rd && reg_addr == 8'h00 |=> reg_rdata == FAMILY_CODE)
    else $error("bad family code");
  a_gap_zero: assert property (reg_rd && reg_addr > 8'h02 |=> reg_rdata == 16'h0000)
    else $error("unmapped read");
  a_soft_rst: assert property (reg_wr && reg_addr == 8'h00 |=> soft_reset_pulse && !mic_bias_on)
    else $error("soft reset");
  a_no_pulse: assert property (!(reg_wr && reg_addr == 8'h00) |=> !soft_reset_pulse)
    else $error("stray pulse");
  a_bias_hiz: assert property (mic_bias_drive_en == mic_bias_on) else $error("bias drive");
  a_mid_wr: assert property (reg_wr && reg_addr == 8'h01 |=> midrail_mode == $past(reg_wdata[2:1])
    && reference_bias_on == $past(reg_wdata[0])) else $error("power one write");
  a_two_wr: assert property (reg_wr && reg_addr == 8'h02 |=> freq_synth_on == $past(reg_wdata[15])
    && left_converter_on == $past(reg_wdata[1])) else $error("power two write");
  c_soft: cover property (reg_wr && reg_addr == 8'h00);
  c_id: cover property (reg_rd && reg_addr == 8'h00);
  c_two: cover property (reg_wr && reg_addr == 8'h02);
endmodule : pei_power_monitor

// ---- verification/tb.sv ----
// Purpose: Self-checking bench for pei_power_regs
// Assumes: 25 MHz clock, rst held 6 cycles
// Notes: Inputs driven on rising edge
`timescale 1ns/100ps
module tb;
  import pei_pkg::*;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic [7:0] reg_addr = 8'h00;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic [15:0] reg_wdata = 16'h0000;
  logic [15:0] reg_rdata;
  logic [1:0] midrail_mode;
  logic reg_rvalid, soft_reset_pulse, mic_bias_on, mic_bias_drive_en, reference_bias_on, freq_synth_on;
  logic thermal_sensor_on, clock_out_pin_on, left_input_path_on, right_input_path_on, left_converter_on;
  logic left_gain_stage_b_on, left_gain_stage_a_on, right_gain_stage_b_on, right_gain_stage_a_on, right_converter_on;
  int mismatches = 0;
  int total_checks = 0;
  wire logic [15:0] p1 = {11'h000, mic_bias_on, 1'h0, midrail_mode, reference_bias_on};
  wire logic [15:0] p2 = {freq_synth_on, thermal_sensor_on, 2'h0, clock_out_pin_on, 1'h0, left_input_path_on,
    right_input_path_on, left_gain_stage_b_on, left_gain_stage_a_on, right_gain_stage_b_on,
    right_gain_stage_a_on, 2'h0, left_converter_on, right_converter_on};
  pei_power_regs u_pei_power_regs (.*);
  initial forever #20 clk = ~clk;
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    total_checks++;
    if (got !== exp) begin
      mismatches++;
      $display("unexpected at %0t: got %h exp %h", $time, got, exp);
    end
  endtask : chk
  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    @(posedge clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge clk);
    reg_wr <= 1'b0;
    #1;
  endtask : wr
  task automatic rd(input logic [7:0] a, input logic [15:0] exp);
    @(posedge clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge clk);
    reg_rd <= 1'b0;
    #1;
    chk(16'(reg_rvalid), 16'h0001);
    chk(reg_rdata, exp);
  endtask : rd
  task automatic t_fields;
    chk(p1 | p2, 16'h0000);
    wr(ADDR_PWR_TWO, 16'hffff);
    chk(p2, 16'hcbf3);
    rd(ADDR_PWR_TWO, 16'hcbf3);
    wr(ADDR_PWR_ONE, 16'hffef);
    chk(p1, 16'h0007);
    rd(ADDR_PWR_ONE, 16'h0007);
    wr(ADDR_PWR_ONE, 16'h0010);
    chk({p1[15:1], mic_bias_drive_en}, 16'h0011);
    $display("t_fields done");
  endtask : t_fields
  task automatic t_modes;
    for (int m = 0; m < 4; m++) begin
      wr(ADDR_PWR_ONE, 16'(m << 1));
      chk(16'(midrail_mode), 16'(m));
    end
    $display("t_modes done");
  endtask : t_modes
  task automatic t_id;
    rd(ADDR_RESET_ID, FAMILY_CODE);
    wr(8'h03, 16'hffff);
    rd(8'h03, 16'h0000);
    rd(ADDR_PWR_TWO, 16'hcbf3);
    $display("t_id done");
  endtask : t_id
  task automatic t_soft;
    // All power enables cleared together
    wr(ADDR_RESET_ID, 16'h1234);
    chk(16'(soft_reset_pulse), 16'h0001);
    chk(p1 | p2, 16'h0000);
    @(posedge clk);
    #1;
    chk(16'(soft_reset_pulse), 16'h0000);
    rd(ADDR_PWR_TWO, 16'h0000);
    rd(ADDR_PWR_ONE, 16'h0000);
    $display("t_soft done");
  endtask : t_soft
  task automatic final_report;
    $display("checks %0d mismatches %0d", total_checks, mismatches);
    if (mismatches == 0 && total_checks > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask : final_report
  initial begin
    repeat (6) @(posedge clk);
    rst <= 1'b0;
    #1;
    t_fields();
    t_modes();
    t_id();
    t_soft();
    final_report();
  end
  initial begin
    #20000;
    mismatches++;
    final_report();
  end
endmodule : tb
bind pei_power_regs pei_power_monitor u_pei_power_monitor (.clk, .rst, .reg_addr, .reg_wr, .reg_wdata, .reg_rd,
  .reg_rdata, .reg_rvalid, .soft_reset_pulse, .mic_bias_on, .mic_bias_drive_en, .midrail_mode,
  .reference_bias_on, .freq_synth_on, .left_converter_on);
